/* File: rtl/bmr_register_file.sv */
// Banked register file with mode selection and three-stage pipeline tracking
module bmr_register_file
    import bmr_pkg::*;
(
    input wire logic core_clk,                 // Core clock
    input wire logic rst,                      // Synchronous reset
    input wire logic [3:0] rd_a_idx,           // Read port A logical index
    input wire logic [3:0] rd_b_idx,           // Read port B logical index
    input wire logic wr_en,                    // Register write strobe
    input wire logic [3:0] wr_idx,             // Write logical index
    input wire logic [31:0] wr_data,           // Write data
    input wire logic [1:0] wr_size,            // 0 byte, 1 half, 2 word
    input wire logic psr_wr_en,                // Current status write
    input wire logic saved_status_register_wr_en,               // Saved status write
    input wire logic [31:0] psr_wr_data,       // Status write data
    input wire logic mode_wr_en,               // Software mode change
    input wire logic [4:0] mode_wr,            // Requested mode code
    input wire logic [2:0] event_code,         // Exception or interrupt
    input wire logic [31:0] event_ret_addr,    // Return address to bank
    input wire logic state_wr_en,              // State change strobe
    input wire logic state_wr_compact,         // New state is compact
    input wire logic advance,                  // Pipeline advances
    input wire logic [31:0] fetch_word,        // Fetched instruction
    output logic [31:0] rd_a_data,             // Read port A data
    output logic [31:0] rd_b_data,             // Read port B data
    output logic [31:0] program_counter,       // Register fifteen
    output logic [31:0] current_status_register, // Current status
    output logic [31:0] saved_status_register, // Saved status, 0 if none
    output logic [4:0] mode,                   // Current mode code
    output logic compact,                      // Compact state flag
    output logic privileged,                   // Mode is privileged
    output logic access_fault,                 // Illegal access seen
    output logic [31:0] decode_instr,          // Instruction in decode
    output logic [31:0] execute_instr          // Instruction in execute
);
    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [31:0] gpr [NUM_GPR];
    logic [31:0] psr [NUM_PSR];
    wire logic [4:0] phy_a;
    wire logic [4:0] phy_b;
    wire logic [4:0] phy_w;
    wire logic legal_a;
    wire logic legal_b;
    wire logic legal_w;

    function automatic logic [2:0] saved_status_register_slot(input logic [4:0] m);
        unique case (m)
            BMR_FIQ: saved_status_register_slot = PSR_FIQ;
            BMR_SVC: saved_status_register_slot = PSR_SVC;
            BMR_ABT: saved_status_register_slot = PSR_ABT;
            BMR_IRQ: saved_status_register_slot = PSR_IRQ;
            BMR_UND: saved_status_register_slot = PSR_UND;
            default: saved_status_register_slot = PSR_CUR;
        endcase
    endfunction

    function automatic logic mode_ok(input logic [4:0] m);
        mode_ok = (m == BMR_USR) || (m == BMR_FIQ) || (m == BMR_IRQ)
                  || (m == BMR_SVC) || (m == BMR_ABT) || (m == BMR_UND)
                  || (m == BMR_SYS);
    endfunction

    bmr_bank_map u_map_a (
        .mode(mode),
        .compact(compact),
        .logical(rd_a_idx),
        .physical(phy_a),
        .legal(legal_a)
    );
    bmr_bank_map u_map_b (
        .mode(mode),
        .compact(compact),
        .logical(rd_b_idx),
        .physical(phy_b),
        .legal(legal_b)
    );
    bmr_bank_map u_map_w (
        .mode(mode),
        .compact(compact),
        .logical(wr_idx),
        .physical(phy_w),
        .legal(legal_w)
    );

    // ------------------------------------------------------------
    // Mode selection
    // ------------------------------------------------------------
    wire logic [4:0] ev_mode;
    wire logic ev_take;
    wire logic [2:0] ev_slot;
    wire logic sw_take;
    wire logic [2:0] cur_slot;
    wire logic [4:0] next_mode;
    wire logic next_compact;
    wire logic [4:0] phy_link;

    // Exception entry always lands in the full state
    assign ev_mode = (event_code == BMR_EV_SWI) ? BMR_SVC :
                     (event_code == BMR_EV_IRQ) ? BMR_IRQ :
                     (event_code == BMR_EV_FIQ) ? BMR_FIQ :
                     (event_code == BMR_EV_DABT) ? BMR_ABT :
                     (event_code == BMR_EV_PABT) ? BMR_ABT :
                     BMR_UND;
    // Banked link slot of the mode being entered, not of the current one
    bmr_bank_map u_map_link (
        .mode(ev_mode),
        .compact(1'b0),
        .logical(REG_LR),
        .physical(phy_link),
        .legal()
    );
    assign ev_take = (event_code != BMR_EV_NONE)
                     && (event_code != 3'h7);
    assign ev_slot = saved_status_register_slot(ev_mode);
    // User mode may not raise its own privilege by a mode write
    assign sw_take = mode_wr_en && mode_ok(mode_wr) && privileged;
    assign cur_slot = saved_status_register_slot(mode);
    assign next_mode = ev_take ? ev_mode : sw_take ? mode_wr : mode;
    assign next_compact = ev_take ? 1'b0 :
                          state_wr_en ? state_wr_compact : compact;

    // ------------------------------------------------------------
    // Write path
    // ------------------------------------------------------------
    wire logic [31:0] old_w;
    wire logic [31:0] sized_w;
    wire logic gpr_we;
    wire logic [31:0] pc_step;
    wire logic [31:0] next_pc;

    assign old_w = gpr[phy_w];
    // Narrow writes merge into the low lanes, upper bits kept
    assign sized_w = (wr_size == 2'h0) ? {old_w[31:8], wr_data[7:0]} :
                     (wr_size == 2'h1) ? {old_w[31:16], wr_data[15:0]} :
                     wr_data;
    assign gpr_we = wr_en && legal_w && !ev_take;
    assign pc_step = compact ? PC_STEP_CMP : PC_STEP_FULL;
    assign next_pc = (gpr_we && wr_idx == REG_PC) ? sized_w :
                     advance ? gpr[REG_PC] + pc_step : gpr[REG_PC];

    always_ff @(posedge core_clk) begin
        if (rst) begin
            for (int i = 0; i < NUM_GPR; i++) begin
                gpr[i] <= GPR_RESET;
            end
        end else begin
            for (int i = 0; i < NUM_GPR; i++) begin
                if (i == int'(REG_PC)) begin
                    gpr[i] <= next_pc;
                end else if (ev_take && i == int'(phy_link)) begin
                    gpr[i] <= event_ret_addr; // Banked link of new mode
                end else if (gpr_we && i == int'(phy_w)) begin
                    gpr[i] <= sized_w;
                end
            end
        end
    end

    // Event wins over status writes; saved copy takes old current status
    always_ff @(posedge core_clk) begin
        if (rst) begin
            for (int i = 0; i < NUM_PSR; i++) begin
                psr[i] <= PSR_RESET;
            end
        end else begin
            for (int i = 0; i < NUM_PSR; i++) begin
                if (ev_take && i == int'(ev_slot)) begin
                    psr[i] <= psr[PSR_CUR];
                end else if (!ev_take && saved_status_register_wr_en && i == int'(cur_slot)
                             && cur_slot != PSR_CUR) begin
                    psr[i] <= psr_wr_data;
                end else if (!ev_take && psr_wr_en && i == int'(PSR_CUR)) begin
                    psr[i] <= psr_wr_data;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Mode, state, outputs and pipeline
    // ------------------------------------------------------------
    wire logic next_priv;
    wire logic [31:0] next_saved_status_register;
    wire logic next_fault;
    wire logic [2:0] next_slot;

    assign next_priv = (next_mode != BMR_USR);
    // Saved status shows only in modes that own one
    // Follows the mode being entered, so it never trails the mode output
    assign next_slot = saved_status_register_slot(next_mode);
    assign next_saved_status_register = (next_slot == PSR_CUR) ? PSR_RESET : psr[next_slot];
    assign next_fault = (wr_en && !legal_w) || (mode_wr_en && !sw_take);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            mode <= MODE_W_RESET;
            compact <= 1'b0;
            privileged <= 1'b1;
        end else begin
            mode <= next_mode;
            compact <= next_compact;
            privileged <= next_priv;
        end
    end

    // Reads reflect storage after the previous edge, one cycle late
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rd_a_data <= GPR_RESET;
            rd_b_data <= GPR_RESET;
            program_counter <= GPR_RESET;
            current_status_register <= PSR_RESET;
            saved_status_register <= PSR_RESET;
            access_fault <= 1'b0;
        end else begin
            rd_a_data <= legal_a ? gpr[phy_a] : GPR_RESET;
            rd_b_data <= legal_b ? gpr[phy_b] : GPR_RESET;
            program_counter <= gpr[REG_PC];
            current_status_register <= psr[PSR_CUR];
            saved_status_register <= next_saved_status_register;
            access_fault <= next_fault;
        end
    end

    // Fetch, decode, execute overlap; flushed on exception entry
    always_ff @(posedge core_clk) begin
        if (rst || ev_take) begin
            decode_instr <= GPR_RESET;
            execute_instr <= GPR_RESET;
        end else if (advance) begin
            decode_instr <= compact ? {16'h0000, fetch_word[15:0]}
                                    : fetch_word;
            execute_instr <= decode_instr;
        end
    end
endmodule

/* File: common/bmr_pkg.sv */
// Package of constants and types for the banked mode register file
// Function
// - Seven operating modes exist: user, fast irq, irq, supervisor, abort, system, undefined.
// - The file holds 37 physical registers: 31 general 32-bit words and six status words.
// - Full state shows sixteen general registers plus the current status and, in an exception mode, a saved status.
// - Register fifteen is the program counter; registers zero to fourteen are general purpose.
// - Fast irq mode swaps in five private copies of registers eight to twelve.
// - Each privileged exception mode has private registers thirteen and fourteen; user and system share one pair.
// - System mode is privileged but uses the user bank only.
// - Compact state reaches registers zero to seven plus program counter, stack pointer, link register and current status.
// - Compact state keeps a banked stack pointer, link register and saved status per exception mode.
// - Compact and full states share one physical register set, so values persist across switches.
// - Mode changes by software request, by a taken interrupt, or by exception entry.
// - A data abort or a prefetch abort enters abort mode.
// - An undecodable instruction enters undefined mode.
// - Instructions are 32 bits in full state and 16 bits in compact state; data are 8, 16 or 32 bits.
// - Three pipeline stages overlap: fetch, decode and execute.
package bmr_pkg;
    localparam int unsigned NUM_GPR = 31;
    localparam int unsigned NUM_PSR = 6;
    localparam int unsigned GPR_IDX_W = 5;
    localparam logic [3:0] REG_SP = 4'hd;
    localparam logic [3:0] REG_LR = 4'he;
    localparam logic [3:0] REG_PC = 4'hf;
    localparam logic [3:0] REG_FIQ_LO = 4'h8;
    // Physical slots: 0..15 shared, then fast irq set and banked pairs
    localparam logic [4:0] PHY_FIQ_R8 = 5'h10;
    localparam logic [4:0] PHY_FIQ_R13 = 5'h15;
    localparam logic [4:0] PHY_SVC_R13 = 5'h17;
    localparam logic [4:0] PHY_ABT_R13 = 5'h19;
    localparam logic [4:0] PHY_IRQ_R13 = 5'h1b;
    localparam logic [4:0] PHY_UND_R13 = 5'h1d;
    // Status slots: 0 current, 1..5 saved per exception mode
    localparam logic [2:0] PSR_CUR = 3'h0;
    localparam logic [2:0] PSR_FIQ = 3'h1;
    localparam logic [2:0] PSR_SVC = 3'h2;
    localparam logic [2:0] PSR_ABT = 3'h3;
    localparam logic [2:0] PSR_IRQ = 3'h4;
    localparam logic [2:0] PSR_UND = 3'h5;
    localparam logic [31:0] GPR_RESET = 32'h0000_0000;
    localparam logic [31:0] PSR_RESET = 32'h0000_0000;
    localparam logic [31:0] PC_STEP_FULL = 32'h0000_0004;
    localparam logic [31:0] PC_STEP_CMP = 32'h0000_0002;
    localparam logic [4:0] MODE_W_RESET = 5'h13;

    typedef enum logic [4:0] {
        BMR_USR = 5'h10,
        BMR_FIQ = 5'h11,
        BMR_IRQ = 5'h12,
        BMR_SVC = 5'h13,
        BMR_ABT = 5'h17,
        BMR_UND = 5'h1b,
        BMR_SYS = 5'h1f
    } bmr_mode_e;

    typedef enum logic [2:0] {
        BMR_EV_NONE = 3'h0,
        BMR_EV_SWI = 3'h1,
        BMR_EV_IRQ = 3'h2,
        BMR_EV_FIQ = 3'h3,
        BMR_EV_DABT = 3'h4,
        BMR_EV_PABT = 3'h5,
        BMR_EV_UNDEF = 3'h6
    } bmr_event_e;
endpackage

/* File: rtl/bmr_bank_map.sv */
// Logical to physical register index map for the banked register file
module bmr_bank_map
    import bmr_pkg::*;
(
    input wire logic [4:0] mode,       // Current mode code
    input wire logic compact,          // Compact 16-bit state
    input wire logic [3:0] logical,    // Logical register number
    output logic [4:0] physical,       // Physical slot index
    output logic legal                 // Access is architecturally visible
);
    wire logic fiq_hi;
    wire logic sp_lr;
    wire logic [4:0] bank_base;
    wire logic [4:0] sp_lr_slot;

    assign fiq_hi = (mode == BMR_FIQ) && (logical >= REG_FIQ_LO)
                    && (logical < REG_SP);
    assign sp_lr = (logical == REG_SP) || (logical == REG_LR);
    // User and system fall back to the shared pair
    assign bank_base = (mode == BMR_FIQ) ? PHY_FIQ_R13 :
                       (mode == BMR_SVC) ? PHY_SVC_R13 :
                       (mode == BMR_ABT) ? PHY_ABT_R13 :
                       (mode == BMR_IRQ) ? PHY_IRQ_R13 :
                       (mode == BMR_UND) ? PHY_UND_R13 : 5'h0d;
    assign sp_lr_slot = bank_base + {4'h0, logical == REG_LR};
    // Compact state sees r0-r7 and r13-r15 only
    assign legal = !compact || (logical < REG_FIQ_LO) || (logical >= REG_SP);
    assign physical = fiq_hi ? PHY_FIQ_R8 + {1'b0, logical - REG_FIQ_LO} :
                      sp_lr ? sp_lr_slot : {1'b0, logical};
endmodule

/* File: verification/bmr_fetch_model.sv */
// Instruction memory model that feeds the fetch stage
module bmr_fetch_model (
    input wire logic [31:0] program_counter, // Fetch address
    output logic [31:0] fetch_word           // Word held at that address
);
    timeunit 1ns;
    timeprecision 1ps;
    // Addresses that differ in bits 15:0 give different words, so a stale fetch shows up
    assign fetch_word = {program_counter[15:0] ^ 16'h5a5a,
                         program_counter[15:0]};
endmodule

/* File: verification/bmr_register_file_sva.sv */
// Concurrent checks on the banked mode register file ports
module bmr_register_file_sva
    import bmr_pkg::*;
(
    input wire logic core_clk,                      // Clock
    input wire logic rst,                           // Reset
    input wire logic wr_en,                         // Write strobe
    input wire logic [3:0] wr_idx,                  // Write index
    input wire logic mode_wr_en,                    // Mode write
    input wire logic [2:0] event_code,              // Event
    input wire logic state_wr_en,                   // State write
    input wire logic advance,                       // Pipeline step
    input wire logic [31:0] fetch_word,             // Fetched word
    input wire logic [31:0] program_counter,        // Register fifteen
    input wire logic [31:0] saved_status_register,  // Saved status
    input wire logic [4:0] mode,                    // Mode
    input wire logic compact,                       // Compact state
    input wire logic privileged,                    // Privileged
    input wire logic access_fault,                  // Fault pulse
    input wire logic [31:0] decode_instr,           // Decode stage
    input wire logic [31:0] execute_instr           // Execute stage
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // A step with nothing else competing for the pipeline or the counter
    sequence clean_step;
        advance && !wr_en && !state_wr_en && event_code == BMR_EV_NONE;
    endsequence
    sequence took(logic [2:0] c);
        event_code == c;
    endsequence
    reset_mode_a: assert property ($fell(rst) |->
        mode == BMR_SVC && !compact && privileged) else $error("reset mode");
    // Counter output trails storage by one edge, so the step shows two later
    pc_step_a: assert property (clean_step |=> ##1 program_counter ==
        $past(program_counter) +
        ($past(compact, 2) ? PC_STEP_CMP : PC_STEP_FULL))
        else $error("counter step");
    pipe_shift_a: assert property (clean_step |=>
        execute_instr == $past(decode_instr)) else $error("pipe shift");
    fetch_take_a: assert property (clean_step ##0 !compact |=>
        decode_instr == $past(fetch_word)) else $error("fetch take");
    fiq_entry_a: assert property (took(BMR_EV_FIQ) |=>
        mode == BMR_FIQ) else $error("fast irq entry");
    abort_entry_a: assert property (took(BMR_EV_DABT) or
        took(BMR_EV_PABT) |=> mode == BMR_ABT) else $error("abort entry");
    undef_entry_a: assert property (took(BMR_EV_UNDEF) |=>
        mode == BMR_UND) else $error("undef entry");
    full_state_a: assert property (event_code inside {[3'h1:3'h6]} |=>
        !compact) else $error("event left compact");
    privilege_a: assert property (privileged == (mode != BMR_USR))
        else $error("privilege flag");
    no_saved_a: assert property (mode inside {BMR_USR, BMR_SYS} |->
        saved_status_register == 32'h0) else $error("saved status");
    compact_fault_a: assert property (compact && wr_en &&
        wr_idx inside {[4'h8:4'hc]} && event_code == BMR_EV_NONE |=>
        access_fault) else $error("compact fault");
    user_lock_a: assert property (mode == BMR_USR && mode_wr_en &&
        event_code == BMR_EV_NONE |=> mode == BMR_USR) else $error("user lock");
endmodule
bind bmr_register_file bmr_register_file_sva chk_u (.core_clk, .rst, .wr_en,
    .wr_idx, .mode_wr_en, .event_code, .state_wr_en, .advance, .fetch_word,
    .program_counter, .saved_status_register, .mode, .compact, .privileged,
    .access_fault, .decode_instr, .execute_instr);

/* File: verification/banked_mode_register_file_bench.sv */
// Self-checking bench for the banked mode register file
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
    $display("Error at %0t: got %h expected %h", $time, g, e); end end
module banked_mode_register_file_bench
    import bmr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] rd_a_idx, rd_b_idx, wr_idx;
    logic wr_en, psr_wr_en, saved_status_register_wr_en, mode_wr_en, state_wr_en, advance;
    logic state_wr_compact, compact, privileged, access_fault;
    logic [31:0] wr_data, psr_wr_data, event_ret_addr, fetch_word, rd_a_data;
    logic [31:0] rd_b_data, program_counter, decode_instr, execute_instr;
    logic [31:0] current_status_register, saved_status_register;
    logic [31:0] got, v, w, a, p, sh [8];
    logic [1:0] wr_size, s;
    logic [4:0] mode_wr, mode;
    logic [2:0] event_code;
    int n_mismatch = 0;
    int tests_run = 0;

    always #5 core_clk = ~core_clk;

    bmr_register_file dut_u (.core_clk, .rst, .rd_a_idx, .rd_b_idx, .wr_en,
        .wr_idx, .wr_data, .wr_size, .psr_wr_en, .saved_status_register_wr_en, .psr_wr_data,
        .mode_wr_en, .mode_wr, .event_code, .event_ret_addr, .state_wr_en,
        .state_wr_compact, .advance, .fetch_word, .rd_a_data, .rd_b_data,
        .program_counter, .current_status_register, .saved_status_register,
        .mode, .compact, .privileged, .access_fault, .decode_instr,
        .execute_instr);
    bmr_fetch_model mem_u (.program_counter, .fetch_word);

    // ------------------------------------------------------------
    // Drivers and expectations
    // ------------------------------------------------------------
    function automatic logic [31:0] merge(logic [31:0] o, n, logic [1:0] z);
        return z == 2'h0 ? {o[31:8], n[7:0]} :
               z == 2'h1 ? {o[31:16], n[15:0]} : n;
    endfunction
    function automatic bmr_mode_e exp_mode(logic [2:0] c);
        case (c)
            BMR_EV_SWI: return BMR_SVC;
            BMR_EV_IRQ: return BMR_IRQ;
            BMR_EV_FIQ: return BMR_FIQ;
            BMR_EV_UNDEF: return BMR_UND;
            default: return BMR_ABT;
        endcase
    endfunction
    task automatic idle();
        {wr_en, psr_wr_en, saved_status_register_wr_en, mode_wr_en, state_wr_en} = '0;
        advance = 1'b0;
        event_code = BMR_EV_NONE;
    endtask
    task automatic wr(logic [3:0] i, logic [31:0] d, logic [1:0] z);
        @(negedge core_clk) {wr_en, wr_idx, wr_data, wr_size} = {1'b1, i, d, z};
        @(negedge core_clk) idle();
    endtask
    task automatic rd(logic [3:0] i, output logic [31:0] d);
        @(negedge core_clk) rd_a_idx = i;
        @(negedge core_clk) d = rd_a_data;
    endtask
    task automatic st(logic cur, logic [31:0] d);
        @(negedge core_clk) {psr_wr_en, saved_status_register_wr_en, psr_wr_data} = {cur, !cur, d};
        @(negedge core_clk) idle();
        @(negedge core_clk);
    endtask
    task automatic ev(logic [2:0] c, logic [31:0] d);
        @(negedge core_clk) {event_code, event_ret_addr} = {c, d};
        @(negedge core_clk) idle();
    endtask
    task automatic mw(logic [4:0] m);
        @(negedge core_clk) {mode_wr_en, mode_wr} = {1'b1, m};
        @(negedge core_clk) idle();
    endtask
    task automatic sw(logic c);
        @(negedge core_clk) {state_wr_en, state_wr_compact} = {1'b1, c};
        @(negedge core_clk) idle();
    endtask
    task automatic adv(int n);
        @(negedge core_clk) advance = 1'b1;
        repeat (n) @(negedge core_clk);
        idle();
        // Counter output trails storage by one edge
        @(negedge core_clk);
    endtask
    task automatic results();
        $display("Compares %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        idle();
        {rd_a_idx, rd_b_idx, wr_idx, wr_data, wr_size, mode_wr} = '0;
        {psr_wr_data, event_ret_addr, state_wr_compact} = '0;
        void'($urandom(78425));
        repeat (12) @(posedge core_clk);
        @(negedge core_clk) rst = 1'b0;
        `CHK({compact, privileged, mode}, {2'b01, BMR_SVC})
        $display("Test reset done");
        for (int i = 0; i < 8; i++) begin
            v = $urandom;
            w = $urandom;
            s = 2'($urandom % 3);
            sh[i] = merge(v, w, s);
            wr(4'(i), v, 2'h2);
            wr(4'(i), w, s);
            rd(4'(i), got);
            `CHK(got, sh[i])
        end
        for (int i = 0; i < 8; i++) begin
            @(negedge core_clk) rd_b_idx = 4'(i);
            @(negedge core_clk) `CHK(rd_b_data, sh[i])
        end
        $display("Test widths done");
        v = $urandom | 32'h1;
        wr(4'h8, v, 2'h2);
        for (int c = 1; c < 7; c++) begin
            p = $urandom;
            a = $urandom;
            st(1'b1, p);
            `CHK(current_status_register, p)
            ev(3'(c), a);
            `CHK(mode, exp_mode(3'(c)))
            rd(4'he, got);
            `CHK(got, a)
            rd(4'h8, got);
            `CHK(got, (c == 3) ? 32'h0 : v)
            `CHK(saved_status_register, p)
            w = $urandom;
            st(1'b0, w);
            `CHK(saved_status_register, w)
        end
        $display("Test events done");
        mw(BMR_SYS);
        st(1'b0, 32'hffff_ffff);
        `CHK({privileged, saved_status_register}, {1'b1, 32'h0})
        a = $urandom;
        wr(4'hd, a, 2'h2);
        mw(BMR_USR);
        rd(4'hd, got);
        `CHK({privileged, got}, {1'b0, a})
        mw(BMR_SVC);
        `CHK({access_fault, mode}, {1'b1, BMR_USR})
        ev(BMR_EV_SWI, 32'h0);
        $display("Test modes done");
        a = $urandom;
        sw(1'b1);
        wr(4'hd, a, 2'h2);
        rd(4'h0, got);
        `CHK(got, sh[0])
        rd(4'h8, got);
        `CHK(got, 32'h0)
        wr(4'h9, a, 2'h2);
        `CHK(access_fault, 1'b1)
        p = program_counter;
        adv(5);
        `CHK(program_counter, p + 32'ha)
        `CHK(decode_instr[31:16], 16'h0)
        ev(BMR_EV_SWI, $urandom);
        `CHK({compact, execute_instr}, 33'h0)
        sw(1'b0);
        rd(4'hd, got);
        `CHK(got, a)
        p = program_counter;
        adv(3);
        `CHK(program_counter, p + 32'hc)
        $display("Test state done");
        results();
    end

    // Whole run is about two hundred cycles; this bound only cuts a hang
    initial begin
        repeat (3000) @(posedge core_clk);
        n_mismatch++;
        results();
    end
endmodule
